// ===== rhps_regs.v
// AXI4-Lite register bank for two root hub port status registers
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rhps_consts.vh"
module rhps_regs #(
    parameter NPORT = 2
) (
    input  wire              ref_clk,
    input  wire              rst,
    input  wire              controller_reset_state,
    input  wire              always_powered_mode,
    input  wire [NPORT-1:0]  fixed_device_flag,
    input  wire [NPORT-1:0]  device_present,
    input  wire [NPORT-1:0]  low_speed_attached,
    input  wire [NPORT-1:0]  overcurrent_flag,
    input  wire [NPORT-1:0]  reset_done,
    input  wire [NPORT-1:0]  resume_done,
    input  wire [NPORT-1:0]  enable_lost,
    input  wire [31:0]       s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [31:0]       s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    output reg  [NPORT-1:0]  port_power_on,
    output reg               irq
);
    // =========================================================
    // Pin synchronisers
    // =========================================================
    // Port status levels arrive from the line side and pass two flops; reset_done, resume_done and enable_lost do not
    wire [NPORT-1:0] pres_s, ls_s, oc_s, fix_s;
    wire             crst_s, apm_s;
    rhps_sync #(.W(4*NPORT+2)) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .d       ({device_present, low_speed_attached, overcurrent_flag,
                   fixed_device_flag, controller_reset_state,
                   always_powered_mode}),
        .q       ({pres_s, ls_s, oc_s, fix_s, crst_s, apm_s})
    );

    // =========================================================
    // Write channel
    // =========================================================
    reg  [31:0] awaddr_r;
    reg  [31:0] wdata_r;
    reg  [3:0]  wstrb_r;
    reg         aw_have_r;
    reg         w_have_r;
    wire        wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
    wire        full_w = (wstrb_r == 4'hf);
    wire        hit_p1 = (awaddr_r == `RHPS_PORT1_ADDR);
    wire        hit_p2 = (awaddr_r == `RHPS_PORT2_ADDR);
    wire        hit_st = (awaddr_r == `RHPS_IRQ_STAT_ADDR);
    wire        hit_mk = (awaddr_r == `RHPS_IRQ_MASK_ADDR);
    wire        wr_ok  = hit_p1 | hit_p2 | hit_st | hit_mk;

    always @(posedge ref_clk) begin
        if (rst) begin
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            awaddr_r      <= 32'h00000000;
            wdata_r       <= 32'h00000000;
            wstrb_r       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RHPS_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_have_r && !s_axi_awready;
            s_axi_wready  <= !w_have_r && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r     <= 1'b1;
                awaddr_r      <= {s_axi_awaddr[31:2], 2'h0};
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r     <= 1'b1;
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `RHPS_RESP_OKAY : `RHPS_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // =========================================================
    // Port registers
    // =========================================================
    // Partial-strobe writes are ignored: every field is a command bit
    wire [NPORT-1:0] port_wr;

    wire [31:0]      port_rd [0:NPORT-1];
    wire [5*NPORT-1:0] port_ev;
    wire [NPORT-1:0] pwr_st;
    genvar g;
    generate
        for (g = 0; g < NPORT; g = g + 1) begin : g_port
            // Ports sit one word apart from the first port register
            assign port_wr[g] = wr_go && full_w
                && (awaddr_r == `RHPS_PORT1_ADDR + 32'h4 * g);
            rhps_port u_port (
                .ref_clk             (ref_clk),
                .rst                 (rst),
                .ctrl_rst            (crst_s),
                .fixed_device_flag   (fix_s[g]),
                .always_powered_mode (apm_s),
                .device_present      (pres_s[g]),
                .low_speed_attached  (ls_s[g]),
                .overcurrent_flag    (oc_s[g]),
                .reset_done          (reset_done[g]),
                .resume_done         (resume_done[g]),
                .enable_lost         (enable_lost[g]),
                .wr                  (port_wr[g]),
                .wdata               (wdata_r),
                .rdata               (port_rd[g]),
                .events              (port_ev[5*g +: 5]),
                .port_power_state    (pwr_st[g])
            );
        end
    endgenerate

    // =========================================================
    // Interrupt status and mask
    // =========================================================
    // Status bit 5*p+k is set by the same event that sets change bit 16+k of port p
    reg  [5*NPORT-1:0] istat_r;
    reg  [5*NPORT-1:0] imask_r;
    wire [5*NPORT-1:0] iclr = (wr_go && full_w && hit_st) ?
                              wdata_r[5*NPORT-1:0] : {5*NPORT{1'b0}};
    always @(posedge ref_clk) begin
        if (rst || crst_s) begin
            istat_r       <= {5*NPORT{1'b0}};
            imask_r       <= {5*NPORT{1'b0}};
            irq           <= 1'b0;
            port_power_on <= {NPORT{1'b0}};
        end else begin
            // New event beats a clear in the same cycle
            istat_r <= (istat_r & ~iclr) | port_ev;
            if (wr_go && full_w && hit_mk)
                imask_r <= wdata_r[5*NPORT-1:0];
            irq           <= |(istat_r & imask_r);
            port_power_on <= pwr_st;
        end
    end

    // =========================================================
    // Read channel
    // =========================================================
    reg [31:0] rd_mux;
    reg        rd_hit;
    always @* begin
        rd_hit = 1'b1;
        case ({s_axi_araddr[31:2], 2'h0})
            `RHPS_PORT1_ADDR:    rd_mux = port_rd[0];
            `RHPS_PORT2_ADDR:    rd_mux = port_rd[1];
            `RHPS_IRQ_STAT_ADDR: rd_mux = {{(32-5*NPORT){1'b0}}, istat_r};
            `RHPS_IRQ_MASK_ADDR: rd_mux = {{(32-5*NPORT){1'b0}}, imask_r};
            default: begin
                rd_mux = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RHPS_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_mux;
                s_axi_rresp   <= rd_hit ? `RHPS_RESP_OKAY
                                        : `RHPS_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // rhps_regs
`default_nettype wire

// ===== rhps_consts.vh
// Constants for the root hub port status register bank
// Notes on behaviour
// - Controller reset state clears both port registers
// - Two 32-bit port registers, reset zero
// - Bit 20 set when port reset finishes
// - Bit 19 set on overcurrent change, W1C
// - Bit 18 set when resume completes
// - Bit 17 set when hardware disables port
// - Bit 16 set on connect or disconnect
// - Bit 16 cleared by writing one
// - Fixed device makes bit 16 reset one; code does so at controller reset only, as fix_s is held zero during rst
// - Bit 9 reads low speed device attached
// - Writing one to bit 9 clears power
// - Bit 8 reads port power state
// - Always powered mode reads bit 8 one
// - Bit 0 reads device present
`ifndef RHPS_CONSTS_VH
`define RHPS_CONSTS_VH
`define RHPS_PORT1_ADDR   32'hfff05054
`define RHPS_PORT2_ADDR   32'hfff05058
`define RHPS_IRQ_STAT_ADDR 32'hfff05060
`define RHPS_IRQ_MASK_ADDR 32'hfff05064
`define RHPS_RESET_VAL    32'h00000000
`define RHPS_B_PRESENT    0
`define RHPS_B_POWER      8
`define RHPS_B_LOWSPEED   9
`define RHPS_B_CONN_CHG   16
`define RHPS_B_ENLOST_CHG 17
`define RHPS_B_RESUME_CHG 18
`define RHPS_B_OC_CHG     19
`define RHPS_B_RST_CHG    20
`define RHPS_RESP_OKAY    2'h0
`define RHPS_RESP_SLVERR  2'h2
`endif

// ===== rhps_sync.v
// Two-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
`default_nettype none
module rhps_sync #(
    parameter W = 1
) (
    input  wire         ref_clk,
    input  wire         rst,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] meta_r;
    always @(posedge ref_clk) begin
        if (rst) begin
            meta_r <= {W{1'b0}};
            q      <= {W{1'b0}};
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // rhps_sync
`default_nettype wire

// ===== rhps_port.v
// One root hub port status register with its change bits
`timescale 1ns/1ps
`default_nettype none
`include "rhps_consts.vh"
module rhps_port (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire        ctrl_rst,
    input  wire        fixed_device_flag,
    input  wire        always_powered_mode,
    input  wire        device_present,
    input  wire        low_speed_attached,
    input  wire        overcurrent_flag,
    input  wire        reset_done,
    input  wire        resume_done,
    input  wire        enable_lost,
    input  wire        wr,
    input  wire [31:0] wdata,
    output wire [31:0] rdata,
    output wire [4:0]  events,
    output wire        port_power_state
);
    reg  present_d_r;
    reg  oc_d_r;
    reg  pwr_r;
    reg  [4:0] chg_r;
    wire [4:0] set_ev;
    wire [4:0] clr;
    // Order: conn, enlost, resume, oc, reset (bits 16..20)
    // connect or disconnect edge
    assign set_ev[0] = device_present ^ present_d_r;
    assign set_ev[1] = enable_lost;
    assign set_ev[2] = resume_done;
    assign set_ev[3] = overcurrent_flag ^ oc_d_r;
    assign set_ev[4] = reset_done;
    assign clr    = wr ? wdata[`RHPS_B_RST_CHG:`RHPS_B_CONN_CHG] : 5'h00;
    assign events = set_ev;

    always @(posedge ref_clk) begin
        if (rst || ctrl_rst) begin
            present_d_r <= 1'b0;
            oc_d_r      <= 1'b0;
            pwr_r       <= 1'b0;
            chg_r       <= {4'h0, fixed_device_flag};
        end else begin
            present_d_r <= device_present;
            oc_d_r      <= overcurrent_flag;
            // Set wins over a clear in the same cycle
            chg_r       <= (chg_r & ~clr) | set_ev;
            if (wr && wdata[`RHPS_B_LOWSPEED])
                pwr_r <= 1'b0;
            else if (wr && wdata[`RHPS_B_POWER])
                pwr_r <= 1'b1;
        end
    end
    assign port_power_state = pwr_r | always_powered_mode;
    assign rdata = {11'h000, chg_r, 6'h00, low_speed_attached & device_present,
                    port_power_state, 7'h00, device_present};
endmodule // rhps_port
`default_nettype wire

// ===== rhps_regs_props.sv
// Checker for the root hub port register bank ports
`timescale 1ns/1ps
`default_nettype none
`include "rhps_consts.vh"
module rhps_regs_props #(
    parameter NPORT = 2
) (
    input wire logic             ref_clk,
    input wire logic             rst,
    input wire logic             controller_reset_state,
    input wire logic             always_powered_mode,
    input wire logic [31:0]      s_axi_awaddr,
    input wire logic             s_axi_awvalid,
    input wire logic             s_axi_awready,
    input wire logic [31:0]      s_axi_wdata,
    input wire logic [3:0]       s_axi_wstrb,
    input wire logic             s_axi_wvalid,
    input wire logic             s_axi_wready,
    input wire logic             s_axi_bvalid,
    input wire logic             s_axi_arvalid,
    input wire logic             s_axi_arready,
    input wire logic [31:0]      s_axi_rdata,
    input wire logic [1:0]       s_axi_rresp,
    input wire logic             s_axi_rvalid,
    input wire logic [NPORT-1:0] port_power_on,
    input wire logic             irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ======
    // Port 1 write; mode pins excluded as they override power
    wire wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid
                   && s_axi_wready;
    wire wr_p1 = wr_both && s_axi_awaddr == `RHPS_PORT1_ADDR
                 && s_axi_wstrb == 4'hf && !always_powered_mode
                 && !controller_reset_state;
    wr_rsp_a: assert property (
        wr_both |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
    rd_rsp_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    aw_pulse_a: assert property (
        s_axi_awready |=> !s_axi_awready) else $error("awready held");
    err_zero_a: assert property (
        s_axi_rvalid && s_axi_rresp == `RHPS_RESP_SLVERR |-> s_axi_rdata == 0)
        else $error("refused read not zero");
    pwr_off_a: assert property (
        wr_p1 && s_axi_wdata[9] |-> ##[1:3] !port_power_on[0])
        else $error("power not cleared");
    pwr_on_a: assert property (
        wr_p1 && s_axi_wdata[8] && !s_axi_wdata[9] |-> ##[1:3] port_power_on[0])
        else $error("power not set");
    always_pwr_a: assert property (
        (always_powered_mode && !controller_reset_state)[*6] |-> &port_power_on)
        else $error("power off in always powered mode");
    ctrl_clear_a: assert property (
        (controller_reset_state && !always_powered_mode)[*6]
        |-> port_power_on == 0 && !irq) else $error("controller reset ignored");
endmodule // rhps_regs_props
bind rhps_regs rhps_regs_props #(.NPORT(NPORT)) u_props (.*);
`default_nettype wire

// ===== rhps_usb_dev.sv
// Model of the devices attached to the two downstream ports
`timescale 1ns/1ps
`default_nettype none
module rhps_usb_dev (
    input  wire logic       ref_clk,
    output var  logic [1:0] device_present,
    output var  logic [1:0] low_speed_attached,
    output var  logic [1:0] overcurrent_flag,
    output var  logic [1:0] reset_done,
    output var  logic [1:0] resume_done,
    output var  logic [1:0] enable_lost
);
    // ======
    initial begin
        {device_present, low_speed_attached, overcurrent_flag} = 6'h0;
        {reset_done, resume_done, enable_lost} = 6'h0;
    end
    // Pins pass two sync flops, so let them land
    task automatic settle();
        repeat (5) @(posedge ref_clk);
    endtask
    task automatic plug(input int p, input logic on, input logic ls);
        device_present[p] <= on;
        low_speed_attached[p] <= on ? ls : ~low_speed_attached[p];
        settle();
    endtask
    task automatic flip_oc(input int p);
        overcurrent_flag[p] <= ~overcurrent_flag[p];
        settle();
    endtask
    task automatic pulse(input int k, input int p);
        if (k == 0) reset_done[p] <= 1'b1;
        else if (k == 1) resume_done[p] <= 1'b1;
        else enable_lost[p] <= 1'b1;
        @(posedge ref_clk);
        {reset_done, resume_done, enable_lost} <= 6'h0;
        settle();
    endtask
endmodule // rhps_usb_dev
`default_nettype wire

// ===== rhps_regs_tb.sv
// Self-checking bench for the root hub port register bank
`timescale 1ns/1ps
`default_nettype none
`include "rhps_consts.vh"
module rhps_regs_tb;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        controller_reset_state = 1'b0;
    logic        always_powered_mode = 1'b0;
    logic [1:0]  fixed_device_flag = 2'h0;
    logic [1:0]  device_present, low_speed_attached, overcurrent_flag;
    logic [1:0]  reset_done, resume_done, enable_lost, port_power_on;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
    logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata, v;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r, b;
    int          n_mismatch = 0, comparisons = 0;
    localparam [31:0] P1 = `RHPS_PORT1_ADDR, P2 = `RHPS_PORT2_ADDR;
    rhps_regs #(.NPORT(2)) DUT (.*);
    rhps_usb_dev u_dev (.*);
    initial forever #2.5 ref_clk = ~ref_clk;
    // ======
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tmo(input int n);
        if (n >= 64) begin
            n_mismatch++;
            $display("[ERR] %0t bus wait timed out", $time);
            stop_test();
        end
    endtask
    // Each access starts on a fresh edge so no signal is driven twice
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge ref_clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 64);
        s_axi_bready <= 1'b0;
        b = s_axi_bresp;
        tmo(n);
    endtask
    task automatic rd(input logic [31:0] a);
        int n;
        n = 0;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge ref_clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 64);
        s_axi_rready <= 1'b0;
        v = s_axi_rdata;
        r = s_axi_rresp;
        tmo(n);
    endtask
    task automatic rc(input logic [31:0] a, input logic [31:0] e);
        rd(a);
        chk(v, e);
    endtask
    // Irq is registered, so look after the edge has landed
    task automatic ck_irq(input logic e);
        @(posedge ref_clk);
        #1;
        chk({31'h0, irq}, {31'h0, e});
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        rc(P1, 32'h0);
        rc(P2, 32'h0);
        wr(P1, 32'h100);
        chk({30'h0, b}, {30'h0, `RHPS_RESP_OKAY});
        rc(P1, 32'h100);
        chk({30'h0, port_power_on}, 32'h1);
        wr(P1, 32'h300);
        rc(P1, 32'h0);
        chk({30'h0, port_power_on}, 32'h0);
        s_axi_wstrb <= 4'h1;
        wr(P1, 32'h100);
        rc(P1, 32'h0);
        s_axi_wstrb <= 4'hf;
        wr(P1, 32'hffe0fcfe);
        rc(P1, 32'h0);
        wr(`RHPS_IRQ_MASK_ADDR, 32'h20);
        u_dev.plug(1, 1'b1, 1'b1);
        rc(P2, 32'h10201);
        ck_irq(1'b1);
        wr(P2, 32'h0);
        rc(P2, 32'h10201);
        wr(P2, 32'h10000);
        rc(P2, 32'h201);
        wr(`RHPS_IRQ_STAT_ADDR, 32'h20);
        ck_irq(1'b0);
        u_dev.flip_oc(0);
        rc(P1, 32'h80000);
        ck_irq(1'b0);
        wr(P1, 32'h80000);
        rc(P1, 32'h0);
        for (int k = 0; k < 3; k++) u_dev.pulse(k, 0);
        rc(P1, 32'h160000);
        wr(P1, 32'h160000);
        rc(P1, 32'h0);
        rd(32'hfff05070);
        chk({v[31:2], r}, {30'h0, `RHPS_RESP_SLVERR});
        wr(32'hfff05070, 32'h1f);
        chk({30'h0, b}, {30'h0, `RHPS_RESP_SLVERR});
        u_dev.plug(1, 1'b0, 1'b0);
        rc(P2, 32'h10000);
        // Falling overcurrent edge counts too; pin idles before reset
        u_dev.flip_oc(0);
        rc(P1, 32'h80000);
        fixed_device_flag <= 2'h1;
        controller_reset_state <= 1'b1;
        repeat (8) @(posedge ref_clk);
        controller_reset_state <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rc(P1, 32'h10000);
        ck_irq(1'b0);
        always_powered_mode <= 1'b1;
        repeat (5) @(posedge ref_clk);
        rc(P1, 32'h10100);
        chk({30'h0, port_power_on}, 32'h3);
        stop_test();
    end
endmodule // rhps_regs_tb
`default_nettype wire
